// File: rtl/hfd_pkg.sv
// Constants and types for the host FIFO DMA and PIO controller.
package hfd_pkg;
    localparam int ADDR_W = 10;
    localparam logic [9:0] OFS_CTRL = 10'h352;
    localparam logic [9:0] OFS_POWER = 10'h353;
    localparam logic [9:0] OFS_STATUS = 10'h354;
    localparam logic [9:0] OFS_COUNT = 10'h355;
    localparam logic [9:0] OFS_DATA = 10'h356;
    localparam logic [9:0] OFS_BURST = 10'h358;
    localparam logic [9:0] OFS_PORT_A = 10'h35a;
    localparam logic [9:0] OFS_PORT_B = 10'h35b;
    localparam logic [9:0] OFS_REV = 10'h35c;
    localparam logic [9:0] OFS_STACK = 10'h35d;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_NARROW = 6;
    localparam int BIT_METHOD = 5;
    localparam int BIT_QUAD = 4;
    localparam int BIT_DIR = 3;
    localparam int BIT_IRQ_EN = 2;
    localparam int BIT_FIFO_CLR = 1;
    localparam int BIT_SW_IRQ = 0;
    localparam int BIT_CLK_STOP = 7;
    localparam int BIT_STK32 = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int FIFO_DEPTH = 128;
    localparam logic [7:0] FIFO_FULL = 8'h80;
    localparam logic [7:0] FIFO_HALF = 8'h40;
    localparam int STACK_DEPTH = 32;
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
    localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);
    localparam int PIN_W = 31;
    localparam logic [30:0] PIN_RESET = 31'h7400_0000;
    typedef enum logic [1:0] {
        BURST_IDLE = 2'b00,
        BURST_ON = 2'b01,
        BURST_OFF = 2'b10
    } hfd_burst_type;
endpackage : hfd_pkg

// File: rtl/hfd_host_dma.sv
// Host data path: FIFO, DMA and PIO moves, burst timers and scratch stack.
`timescale 1ns/1ps
module hfd_host_dma #(
    parameter logic [2:0] REV_CODE = 3'h5
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [hfd_pkg::ADDR_W-1:0] bus_addr,
    input wire logic bus_ior_n,
    input wire logic bus_iow_n,
    input wire logic bus_sbhe_n,
    input wire logic bus_dack_n,
    input wire logic bus_tc,
    input wire logic [15:0] bus_data_in,
    output logic [15:0] bus_data_out,
    output logic bus_data_oe_n,
    output logic bus_drq,
    output logic bus_irq,
    input wire logic [7:0] int_cond,
    input wire logic scsi_push,
    input wire logic [7:0] scsi_push_data,
    input wire logic scsi_pop,
    output logic [7:0] scsi_pop_data,
    output logic [7:0] user_port_first_value,
    output logic [7:0] user_port_second_value,
    output logic clock_stop
);
    import hfd_pkg::*;

    // REV_CODE is an arbitrary value.

    function automatic logic fits(input logic [7:0] level, input logic [7:0] need);
        fits = level >= need;
    endfunction : fits

    // =====================================================
    // Pin synchronisers
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic ior_last;
    logic iow_last;
    logic [28:0] cap;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= PIN_RESET;
            pin_sync <= PIN_RESET;
            ior_last <= 1'b1;
            iow_last <= 1'b1;
        end else begin
            pin_meta <= {bus_ior_n, bus_iow_n, bus_dack_n, bus_tc, bus_sbhe_n, bus_addr, bus_data_in};
            pin_sync <= pin_meta;
            ior_last <= pin_sync[30];
            iow_last <= pin_sync[29];
        end
    end

    // Address and data are held while a strobe is low, so the access is taken
    // at the strobe's trailing edge with stable values.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cap <= PIN_RESET[28:0];
        end else if (!pin_sync[30] || !pin_sync[29]) begin
            cap <= pin_sync[28:0];
        end
    end

    wire ior_n = pin_sync[30];
    wire iow_n = pin_sync[29];
    wire rd_end = ior_n && !ior_last;
    wire wr_end = iow_n && !iow_last;
    wire cap_dack_n = cap[28];
    wire cap_tc = cap[27];
    wire cap_sbhe_n = cap[26];
    wire [9:0] cap_addr = cap[25:16];
    wire [15:0] wdata = cap[15:0];

    // =====================================================
    // Control registers
    logic [7:0] ctrl;
    logic full_stack_enable;
    logic [4:0] stk_ptr;
    logic [7:0] burst_timing;
    logic host_transfer_done;

    wire transfer_enable = ctrl[BIT_ENABLE];
    wire narrow_width_select = ctrl[BIT_NARROW];
    wire transfer_method_select = ctrl[BIT_METHOD];
    wire quad_byte_pio_mode = ctrl[BIT_QUAD];
    wire dir_fill = ctrl[BIT_DIR];
    wire irq_master_enable = ctrl[BIT_IRQ_EN];
    wire software_irq_request = ctrl[BIT_SW_IRQ];
    wire [3:0] burst_on_time = burst_timing[7:4];
    wire [3:0] burst_off_time = burst_timing[3:0];
    wire run = !clock_stop;

    // =====================================================
    // Address decode
    wire redirect = quad_byte_pio_mode && (cap_addr == OFS_BURST || cap_addr == OFS_PORT_A);
    wire [9:0] eff_addr = redirect ? OFS_DATA : cap_addr;
    wire dma_cyc = !cap_dack_n;
    wire data_hit = eff_addr[9:1] == OFS_DATA[9:1];
    wire data_acc = dma_cyc || data_hit;
    wire reg_hit = eff_addr >= OFS_CTRL && eff_addr <= OFS_STACK;
    wire width16 = dma_cyc ? !narrow_width_select : (!cap_sbhe_n && !eff_addr[0]);
    wire [7:0] nbytes = width16 ? 8'h02 : 8'h01;
    wire [7:0] dma_bytes = narrow_width_select ? 8'h01 : 8'h02;
    wire reg_wr = wr_end && !dma_cyc && !data_hit && (run || eff_addr == OFS_POWER);
    wire reg_rd = rd_end && !dma_cyc && !data_hit && run;
    wire wr_ctrl = reg_wr && eff_addr == OFS_CTRL;
    wire fifo_clr = wr_ctrl && wdata[BIT_FIFO_CLR];
    wire stk_wr = reg_wr && run && eff_addr == OFS_STACK;
    wire stk_acc = stk_wr || (reg_rd && eff_addr == OFS_STACK);

    // =====================================================
    // Host FIFO
    logic [7:0] fifo [FIFO_DEPTH];
    logic [6:0] wp;
    logic [6:0] rp;
    logic [7:0] fifo_byte_count;

    wire [7:0] space = FIFO_FULL - fifo_byte_count;
    // A data access is honoured only in the mode that matches its cycle type.
    wire mode_ok = dma_cyc ? transfer_method_select : !transfer_method_select;
    wire xfer_ok = transfer_enable && run && mode_ok && !(dma_cyc && host_transfer_done);
    wire host_push = wr_end && data_acc && xfer_ok && dir_fill && fits(space, nbytes);
    wire host_pop = rd_end && data_acc && xfer_ok && !dir_fill && fits(fifo_byte_count, nbytes);
    wire s_push = scsi_push && run && !dir_fill && fits(space, 8'h01);
    wire s_pop = scsi_pop && run && dir_fill && fits(fifo_byte_count, 8'h01);
    wire [7:0] push_n = (host_push ? nbytes : 8'h00) + (s_push ? 8'h01 : 8'h00);
    wire [7:0] pop_n = (host_pop ? nbytes : 8'h00) + (s_pop ? 8'h01 : 8'h00);
    wire [7:0] next_count = fifo_clr ? 8'h00 : fifo_byte_count + push_n - pop_n;
    wire [6:0] wp_inc = wp + 7'h01;
    wire [6:0] rp_inc = rp + 7'h01;

    always_ff @(posedge clock) begin
        if (host_push) begin
            fifo[wp] <= wdata[7:0];
        end
        if (host_push && width16) begin
            fifo[wp_inc] <= wdata[15:8];
        end
        if (s_push) begin
            fifo[wp] <= scsi_push_data;
        end
    end

    // Clearing resets both pointers with the count so stale bytes are never seen.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp <= 7'h00;
            rp <= 7'h00;
            fifo_byte_count <= 8'h00;
        end else begin
            wp <= fifo_clr ? 7'h00 : wp + push_n[6:0];
            rp <= fifo_clr ? 7'h00 : rp + pop_n[6:0];
            fifo_byte_count <= next_count;
        end
    end

    // =====================================================
    // Status flags
    wire fifo_full_flag = fifo_byte_count == FIFO_FULL;
    wire fifo_empty_flag = fifo_byte_count == 8'h00;
    wire fifo_half_flag = fits(fifo_byte_count, FIFO_HALF);
    wire [7:0] level = dir_fill ? space : fifo_byte_count;
    wire word_ready_flag = !transfer_method_select && fits(level, 8'h02);
    wire two_word_ready_flag = quad_byte_pio_mode && fits(level, 8'h04);
    wire irq_pending_flag = (|int_cond) || software_irq_request;
    wire [7:0] status = {host_transfer_done, word_ready_flag, irq_pending_flag, fifo_full_flag,
                         fifo_empty_flag, fifo_half_flag, two_word_ready_flag, 1'b0};

    // =====================================================
    // Scratch stack
    logic [7:0] stack [STACK_DEPTH];
    wire [4:0] stk_idx = {stk_ptr[4] && full_stack_enable, stk_ptr[3:0]};

    always_ff @(posedge clock) begin
        if (stk_wr) begin
            stack[stk_idx] <= wdata[7:0];
        end
    end

    // =====================================================
    // Register writes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            clock_stop <= 1'b0;
            full_stack_enable <= 1'b0;
            stk_ptr <= 5'h00;
            burst_timing <= REG_RESET;
            user_port_first_value <= REG_RESET;
            user_port_second_value <= REG_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wdata[7:0] & ~(8'h01 << BIT_FIFO_CLR);
            end
            if (reg_wr && eff_addr == OFS_POWER) begin
                clock_stop <= wdata[BIT_CLK_STOP];
                full_stack_enable <= wdata[BIT_STK32];
                stk_ptr <= wdata[4:0];
            end else if (stk_acc) begin
                stk_ptr <= stk_idx + 5'h01;
            end
            if (reg_wr && eff_addr == OFS_BURST) begin
                burst_timing <= wdata[7:0];
            end
            if (reg_wr && eff_addr == OFS_PORT_A) begin
                user_port_first_value <= wdata[7:0];
            end
            if (reg_wr && eff_addr == OFS_PORT_B) begin
                user_port_second_value <= wdata[7:0];
            end
        end
    end

    // Terminal count on a taken DMA unit ends the host side until the
    // enable bit is dropped; it never raises an interrupt.
    wire done_set = (host_push || host_pop) && dma_cyc && cap_tc;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            host_transfer_done <= 1'b0;
        end else if (done_set) begin
            host_transfer_done <= 1'b1;
        end else if (!transfer_enable) begin
            host_transfer_done <= 1'b0;
        end
    end

    // =====================================================
    // Burst timers
    hfd_burst_type burst_state;
    hfd_burst_type next_state;
    logic [6:0] us_cnt;
    logic [3:0] burst_cnt;

    wire want = transfer_enable && transfer_method_select && run && !host_transfer_done
                && fits(level, dma_bytes);
    wire tick = us_cnt == US_LAST;
    wire on_done = burst_on_time != 4'h0 && tick && burst_cnt == burst_on_time - 4'h1;
    wire off_done = tick && burst_cnt == burst_off_time - 4'h1;
    wire has_off = burst_off_time != 4'h0;

    always_comb begin
        next_state = burst_state;
        case (burst_state)
            BURST_IDLE: begin
                if (want) begin
                    next_state = BURST_ON;
                end
            end
            BURST_ON: begin
                if (!want || on_done) begin
                    next_state = has_off ? BURST_OFF : BURST_IDLE;
                end
            end
            BURST_OFF: begin
                if (off_done) begin
                    next_state = BURST_IDLE;
                end
            end
            default: begin
                next_state = BURST_IDLE;
            end
        endcase
    end

    // Each state starts its microsecond count afresh, so a burst that runs to its limit lasts
    // whole microseconds, and a gap lasts whole microseconds plus at least one idle cycle.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            burst_state <= BURST_IDLE;
            us_cnt <= 7'h00;
            burst_cnt <= 4'h0;
            bus_drq <= 1'b0;
        end else begin
            burst_state <= next_state;
            us_cnt <= (next_state != burst_state || tick) ? 7'h00 : us_cnt + 7'h01;
            burst_cnt <= (next_state != burst_state) ? 4'h0 : burst_cnt + {3'h0, tick};
            bus_drq <= next_state == BURST_ON;
        end
    end

    // =====================================================
    // Read path and interrupt pin
    // The FIFO and stack arrays have no reset, so a byte that was never written
    // reads as unknown; software must not rely on its value.
    wire [7:0] reg_byte =
        eff_addr == OFS_CTRL ? ctrl :
        eff_addr == OFS_POWER ? {clock_stop, full_stack_enable, 6'h00} :
        eff_addr == OFS_STATUS ? status :
        eff_addr == OFS_COUNT ? fifo_byte_count :
        eff_addr == OFS_BURST ? burst_timing :
        eff_addr == OFS_PORT_A ? user_port_first_value :
        eff_addr == OFS_PORT_B ? user_port_second_value :
        eff_addr == OFS_REV ? {5'h00, REV_CODE} :
        eff_addr == OFS_STACK ? stack[stk_idx] : 8'h00;
    wire [7:0] high_byte = width16 ? fifo[rp_inc] : 8'h00;
    wire [15:0] read_val = data_acc ? {high_byte, fifo[rp]} : {8'h00, reg_byte};
    wire drive = !ior_n && !ior_last && (dma_cyc || reg_hit);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_data_out <= 16'h0000;
            bus_data_oe_n <= 1'b1;
            bus_irq <= 1'b0;
            scsi_pop_data <= 8'h00;
        end else begin
            bus_data_out <= read_val;
            bus_data_oe_n <= !drive;
            bus_irq <= irq_master_enable && irq_pending_flag;
            scsi_pop_data <= fifo[rp];
        end
    end

    // =====================================================
    // Assertions
    // Counting the cycles of the current request keeps the burst limit check
    // free of a long repetition, which the tools would have to unroll.
    logic [10:0] on_run;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            on_run <= 11'h000;
        end else begin
            on_run <= bus_drq ? on_run + 11'h001 : 11'h000;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_irq_masked: assert property (!irq_master_enable |=> !bus_irq)
        else $error("IRQ raised with master enable clear");
    a_swirq_drives: assert property (irq_master_enable && software_irq_request |=> bus_irq)
        else $error("Software interrupt did not drive IRQ");
    a_fifo_clear: assert property (fifo_clr |=> fifo_byte_count == 8'h00 && !ctrl[BIT_FIFO_CLR])
        else $error("FIFO clear did not zero the count");
    a_done_blocks: assert property (host_transfer_done |=> !bus_drq)
        else $error("DMA request while host done is set");
    a_pio_no_drq: assert property (!transfer_method_select |=> !bus_drq)
        else $error("DMA request raised in PIO mode");
    a_off_gap: assert property ($rose(burst_state == BURST_OFF) |-> !bus_drq [*8])
        else $error("DMA request inside burst-off time");
    a_on_limit: assert property (burst_on_time != 4'h0 && bus_drq
                                 |-> on_run <= 11'(burst_on_time) * 11'(US_CYCLES))
        else $error("Burst longer than burst-on time");
    a_stack_step: assert property (stk_acc && !(reg_wr && eff_addr == OFS_POWER)
                                   |=> stk_ptr == $past(stk_idx) + 5'h01)
        else $error("Stack pointer did not advance");
    a_full_count: assert property (fifo_byte_count <= FIFO_FULL)
        else $error("FIFO count above depth");
    a_stop_freeze: assert property (clock_stop |=> $stable(fifo_byte_count) && $stable(ctrl))
        else $error("FIFO or control changed while the clock is stopped");
    a_stop_no_drq: assert property (clock_stop |=> !bus_drq)
        else $error("DMA request while the clock is stopped");
    a_done_holds: assert property (host_transfer_done && transfer_enable |=> host_transfer_done)
        else $error("Host done cleared while the enable bit is set");
    a_narrow_lanes: assert property (data_acc && !width16 |=> bus_data_out[15:8] == 8'h00)
        else $error("High byte lane driven on a narrow transfer");
    a_irq_follows: assert property (irq_master_enable && irq_pending_flag |=> bus_irq)
        else $error("Pending interrupt did not drive IRQ");
    a_ports_hold: assert property (!reg_wr |=> $stable(user_port_first_value)
                                   && $stable(user_port_second_value))
        else $error("User port changed without a host write");

    c_burst_split: cover property (burst_state == BURST_ON ##1 burst_state == BURST_OFF);
    c_host_done: cover property ($rose(host_transfer_done));
    c_fifo_full: cover property (fifo_full_flag);
    c_stack_wrap: cover property (stk_acc && stk_idx == 5'h1f);
    c_quad_redirect: cover property (redirect && wr_end);
endmodule : hfd_host_dma

// File: tb/hfd_host_model.sv
// Host CPU and system DMA controller model driving the ISA side of the block.
`timescale 1ns/1ps
module hfd_host_model (
    input wire logic clock,
    output logic [9:0] bus_addr,
    output logic bus_ior_n,
    output logic bus_iow_n,
    output logic bus_sbhe_n,
    output logic bus_dack_n,
    output logic bus_tc,
    output logic [15:0] bus_data_in,
    input wire logic [15:0] bus_data_out,
    input wire logic bus_data_oe_n
);
    logic [15:0] rd_data;
    logic rd_oe_n;
    initial begin
        bus_addr = 10'h000;
        bus_ior_n = 1'b1;
        bus_iow_n = 1'b1;
        bus_sbhe_n = 1'b1;
        bus_dack_n = 1'b1;
        bus_tc = 1'b0;
        bus_data_in = 16'h0000;
    end
    // =====================================================================
    // One strobe cycle, I/O or DMA.
    // Released address and data lines show the inverse of their last value, so a late capture cannot match by luck.
    task automatic cycle(input logic wr, input logic dma, input logic [9:0] a, input logic [15:0] d,
                         input logic wide, input logic tc, input int hold);
        @(posedge clock);
        #1;
        bus_addr = a;
        bus_data_in = d;
        bus_sbhe_n = !wide;
        bus_dack_n = !dma;
        bus_tc = tc;
        bus_iow_n = !wr;
        bus_ior_n = wr;
        repeat (hold) @(posedge clock);
        rd_data = bus_data_out;
        rd_oe_n = bus_data_oe_n;
        #1;
        bus_iow_n = 1'b1;
        bus_ior_n = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        bus_addr = ~a;
        bus_data_in = ~d;
        bus_sbhe_n = 1'b1;
        bus_dack_n = 1'b1;
        bus_tc = 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask : cycle
endmodule : hfd_host_model

// File: tb/testbench.sv
// Self-checking bench for the host FIFO DMA and PIO controller.
`timescale 1ns/1ps
module testbench;
    import hfd_pkg::*;
    // Revision code value is arbitrary.
    localparam logic [2:0] CHIP_REVISION = 3'h3;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] bus_addr;
    logic bus_ior_n, bus_iow_n, bus_sbhe_n, bus_dack_n, bus_tc, bus_data_oe_n, bus_drq, bus_irq, clock_stop;
    logic [15:0] bus_data_in, bus_data_out, seed, rv, w0;
    logic [7:0] int_cond = 8'h00;
    logic scsi_push = 1'b0;
    logic [7:0] scsi_push_data = 8'h00;
    logic scsi_pop = 1'b0;
    logic [7:0] scsi_pop_data, port_a, port_b, up_a, up_b;
    int num_errors = 0;
    int cmp_count = 0;
    int n;
    always #5 clock = ~clock;
    hfd_host_dma #(.REV_CODE(CHIP_REVISION)) u_dut (.clock(clock), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_ior_n(bus_ior_n), .bus_iow_n(bus_iow_n), .bus_sbhe_n(bus_sbhe_n), .bus_dack_n(bus_dack_n),
        .bus_tc(bus_tc), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
        .bus_drq(bus_drq), .bus_irq(bus_irq), .int_cond(int_cond), .scsi_push(scsi_push),
        .scsi_push_data(scsi_push_data), .scsi_pop(scsi_pop), .scsi_pop_data(scsi_pop_data),
        .user_port_first_value(up_a), .user_port_second_value(up_b), .clock_stop(clock_stop));
    hfd_host_model hm (.clock(clock), .bus_addr(bus_addr), .bus_ior_n(bus_ior_n), .bus_iow_n(bus_iow_n),
        .bus_sbhe_n(bus_sbhe_n), .bus_dack_n(bus_dack_n), .bus_tc(bus_tc), .bus_data_in(bus_data_in),
        .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n));
    // =====================================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // Status flags while the host fills the FIFO in PIO mode.
    function automatic logic [15:0] stat_exp(input int cnt);
        return {9'h000, (FIFO_DEPTH - cnt) >= 2, 1'b0, cnt == FIFO_DEPTH, cnt == 0, cnt >= 64, 2'b00};
    endfunction : stat_exp
    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // Slow answers come from a random strobe length.
    task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic wide = 1'b0);
        hm.cycle(1'b1, 1'b0, a, d, wide, 1'b0, 6 + int'(seed[1:0]));
        seed = lfsr(seed);
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic wide = 1'b0);
        hm.cycle(1'b0, 1'b0, a, 16'h0000, wide, 1'b0, 6 + int'(seed[1:0]));
        rv = hm.rd_data;
        seed = lfsr(seed);
    endtask : rd
    task automatic chk_rd(input logic [9:0] a, input logic [15:0] m, input logic [15:0] e, input string what);
        rd(a);
        check(rv & m, e & m, what);
        check({15'h0000, hm.rd_oe_n}, 16'h0000, "read not driven");
    endtask : chk_rd
    task automatic dma(input logic [15:0] d, input logic tc = 1'b0);
        hm.cycle(1'b1, 1'b1, 10'h000, d, 1'b1, tc, 6);
    endtask : dma
    task automatic push(input logic [7:0] d);
        @(posedge clock);
        #1;
        scsi_push = 1'b1;
        scsi_push_data = d;
        @(posedge clock);
        #1;
        scsi_push = 1'b0;
    endtask : push
    task automatic pop_chk(input logic [7:0] e);
        check({8'h00, scsi_pop_data}, {8'h00, e}, "pop data");
        @(posedge clock);
        #1;
        scsi_pop = 1'b1;
        @(posedge clock);
        #1;
        scsi_pop = 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask : pop_chk
    task automatic wait_drq(input logic lvl);
        n = 0;
        while (bus_drq !== lvl) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 400) begin
                num_errors++;
                complete_run();
            end
        end
    endtask : wait_drq
    // =====================================================================
    // Main sequence
    initial begin
        seed = 16'h0010;
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clock);
        chk_rd(OFS_CTRL, 16'h00FF, 16'h0000, "ctrl reset");
        chk_rd(OFS_POWER, 16'h00FF, 16'h0000, "power reset");
        chk_rd(OFS_STATUS, 16'h00FF, 16'h0008, "status reset");
        chk_rd(OFS_COUNT, 16'h00FF, 16'h0000, "count reset");
        chk_rd(OFS_BURST, 16'h00FF, 16'h0000, "burst reset");
        wr(OFS_REV, 16'h00FF);
        chk_rd(OFS_REV, 16'h00FF, {13'h0000, CHIP_REVISION}, "revision");
        rd(10'h350);
        check({15'h0000, hm.rd_oe_n}, 16'h0001, "unmapped driven");
        for (int i = 0; i < 4; i++) begin
            port_a = seed[7:0];
            port_b = seed[15:8];
            wr(OFS_PORT_A, {8'h00, port_a});
            wr(OFS_PORT_B, {8'h00, port_b});
            check({up_a, up_b}, {port_a, port_b}, "port pins");
            chk_rd(OFS_PORT_A, 16'h00FF, {8'h00, port_a}, "port a");
            chk_rd(OFS_PORT_B, 16'h00FF, {8'h00, port_b}, "port b");
        end
        int_cond = seed[7:0] | 8'h01;
        chk_rd(OFS_STATUS, 16'h0020, 16'h0020, "pending");
        check({15'h0000, bus_irq}, 16'h0000, "irq masked");
        wr(OFS_CTRL, 16'h0004);
        check({15'h0000, bus_irq}, 16'h0001, "irq on");
        int_cond = 8'h00;
        repeat (3) @(posedge clock);
        check({15'h0000, bus_irq}, 16'h0000, "irq off");
        wr(OFS_CTRL, 16'h0001);
        check({15'h0000, bus_irq}, 16'h0000, "sw masked");
        wr(OFS_CTRL, 16'h0005);
        check({15'h0000, bus_irq}, 16'h0001, "sw irq");
        wr(OFS_CTRL, 16'h0000);
        wr(OFS_POWER, 16'h005E);
        chk_rd(OFS_POWER, 16'h00FF, 16'h0040, "power read");
        for (int i = 0; i < 3; i++) wr(OFS_STACK, 16'h00A0 + 16'(i));
        wr(OFS_POWER, 16'h0010);
        chk_rd(OFS_STACK, 16'h00FF, 16'h00A2, "stack mask");
        wr(OFS_POWER, 16'h005E);
        chk_rd(OFS_STACK, 16'h00FF, 16'h00A0, "stack top");
        chk_rd(OFS_STACK, 16'h00FF, 16'h00A1, "stack next");
        wr(OFS_POWER, 16'h0080);
        check({15'h0000, clock_stop}, 16'h0001, "stop");
        wr(OFS_PORT_A, {8'h00, ~port_a});
        wr(OFS_POWER, 16'h0000);
        check({8'h00, up_a}, {8'h00, port_a}, "frozen");
        // Fill by PIO; a DMA cycle here is refused and no request is raised.
        wr(OFS_CTRL, 16'h008A);
        chk_rd(OFS_CTRL, 16'h00FF, 16'h0088, "clear bit");
        dma(16'h1234);
        check({15'h0000, bus_drq}, 16'h0000, "drq in pio");
        w0 = seed;
        for (int i = 1; i <= 65; i++) begin
            wr(OFS_DATA, seed, 1'b1);
            chk_rd(OFS_STATUS, 16'h005C, stat_exp(i > 64 ? 128 : 2 * i), "fill");
        end
        chk_rd(OFS_COUNT, 16'h00FF, 16'h0080, "full count");
        pop_chk(w0[7:0]);
        pop_chk(w0[15:8]);
        wr(OFS_CTRL, 16'h008A);
        chk_rd(OFS_COUNT, 16'h00FF, 16'h0000, "cleared");
        wr(OFS_CTRL, 16'h009A);
        wr(OFS_BURST, 16'h5A5A, 1'b1);
        wr(OFS_PORT_A, 16'hA5A5, 1'b1);
        chk_rd(OFS_COUNT, 16'h00FF, 16'h0004, "quad count");
        chk_rd(OFS_STATUS, 16'h0002, 16'h0002, "two word");
        check({8'h00, up_a}, {8'h00, port_a}, "quad port");
        wr(OFS_CTRL, 16'h0082);
        push(8'h11);
        push(8'h22);
        push(8'h33);
        rd(OFS_DATA, 1'b1);
        check(rv, 16'h2211, "word read");
        rd(OFS_DATA);
        check(rv & 16'h00FF, 16'h0033, "byte read");
        chk_rd(OFS_STATUS, 16'h001C, 16'h0008, "drained");
        // DMA fill with a narrow terminal unit, then a refused cycle.
        wr(OFS_CTRL, 16'h00AA);
        wr(OFS_DATA, 16'h7777, 1'b1);
        chk_rd(OFS_COUNT, 16'h00FF, 16'h0000, "pio refused");
        wait_drq(1'b1);
        dma(16'hBEEF);
        wr(OFS_CTRL, 16'h00E8);
        dma(16'h00C4, 1'b1);
        dma(16'h00D5);
        chk_rd(OFS_COUNT, 16'h00FF, 16'h0003, "dma count");
        chk_rd(OFS_STATUS, 16'h0080, 16'h0080, "done set");
        check({15'h0000, bus_drq}, 16'h0000, "drq after done");
        pop_chk(8'hEF);
        pop_chk(8'hBE);
        pop_chk(8'hC4);
        wr(OFS_CTRL, 16'h0028);
        chk_rd(OFS_STATUS, 16'h0080, 16'h0000, "done clear");
        wr(OFS_BURST, 16'h0011);
        wr(OFS_CTRL, 16'h00A8);
        wait_drq(1'b1);
        wait_drq(1'b0);
        check({15'h0000, n >= US_CYCLES - 2 && n <= US_CYCLES + 2}, 16'h0001, "burst on");
        wait_drq(1'b1);
        check({15'h0000, n >= US_CYCLES - 2 && n <= US_CYCLES + 2}, 16'h0001, "burst off");
        wr(OFS_BURST, 16'h0000);
        wait_drq(1'b1);
        n = 0;
        repeat (250) begin
            @(posedge clock);
            #1;
            n += int'(bus_drq !== 1'b1);
        end
        check(16'(n), 16'h0000, "no limit");
        complete_run();
    end
endmodule : testbench
